/* File: shared/sief_regs.svh */
// opcodes, status field positions, ident codes, pin idle levels and framing constants
`ifndef SIEF_REGS_SVH
`define SIEF_REGS_SVH
`define SIEF_OP_LATCH_SET    8'h06
`define SIEF_OP_LATCH_CLEAR  8'h04
`define SIEF_OP_IDENT_READ   8'h9f
`define SIEF_OP_STATUS_READ  8'h05
`define SIEF_OP_STATUS_WRITE 8'h01
`define SIEF_OP_DATA_READ    8'h03
`define SIEF_OP_PAGE_REWRITE 8'h02
`define SIEF_OP_PAGE_BURN    8'h0a
`define SIEF_OP_PAGE_CLEAR   8'hdb
`define SIEF_OP_SECTOR_CLEAR 8'hd8
`define SIEF_ST_BUSY_BIT     0
`define SIEF_ST_LATCH_BIT    1
`define SIEF_ST_FIELD_LO     2
`define SIEF_ST_FIELD_HI     5
`define SIEF_FIELD_MAX       4'hf
`define SIEF_FIELD_RESET     4'h0
`define SIEF_ID_MAKER        8'h5a // arbitrary maker code
`define SIEF_ID_TYPE         8'h3c // arbitrary type code
`define SIEF_ID_SIZE         8'h07 // arbitrary capacity code
`define SIEF_PIN_IDLE        6'h26 // idle select, clock, data, protect, reset, busy
`define SIEF_BYTE_BITS       3'h7
`define SIEF_ADDR_BYTES      2'h3
`define SIEF_PAGE_HI         11
`define SIEF_PAGE_LO         8
`endif

/* File: shared/sief_pkg.sv */
// types shared by the instruction front end
package sief_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_DATA_IN, ST_OUT, ST_IGNORE
  } sief_state_t;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_LATCH_SET, CMD_LATCH_CLEAR, CMD_IDENT, CMD_STATUS_RD,
    CMD_STATUS_WR, CMD_DATA_RD, CMD_REWRITE, CMD_BURN, CMD_PAGE_CLR,
    CMD_SECTOR_CLR
  } sief_cmd_t;
endpackage : sief_pkg

/* File: rtl/sief_sync.sv */
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
module sief_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,   // sampling clock
  input  wire logic         rst,   // async reset, active high
  input  wire logic [W-1:0] d,     // asynchronous inputs
  output logic      [W-1:0] q      // synchronised outputs
);
  logic [W-1:0] meta_ff;
  // reset to the idle pin levels so no false edge follows reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= INIT;
      q       <= INIT;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule : sief_sync

/* File: rtl/sief_front_end.sv */
// serial eeprom instruction decoding front end
`timescale 1ns/100ps
`include "sief_regs.svh"
// Behaviour
// - opcode, address and data travel msb first, sampled on rising clock.
// - eight-bit opcodes with the fixed code set.
// - read and status read shift out data until deselect.
// - modifying instructions rejected unless bit count is multiple of eight.
// - array accesses ignored while an internal cycle runs.
// - framed latch set command sets the write permit latch.
// - framed latch clear command clears the write permit latch.
// - latch cleared at power-up and after clear or modify commands.
// - identification shifts out 24 bits on falling edges, maker first.
// - identification read during a cycle is not decoded.
// - deselect ends identification read; device waits for next select.
// - status: b7,b6 zero, field b5..b2, latch b1, busy b0; masked.
// - latch and busy volatile, read only, changed only internally.
// - status readable any time and repeated while clocked.
// - busy reads one during a cycle, zero otherwise.
// - modify instructions execute only when latch is one.
// - latch cleared after modify, kept when protected fast sector hit.
// - protect field N sizes the fast sector at lowest N pages.
// - protectable area at most 15 pages, top page never protected.
// - write-protect low rejects modifies in the fast sector.
// - inputs latched on rising edges, outputs change on falling edges.
// - reset pin clears latch, does not stop a running cycle.
module sief_front_end (
  input  wire logic        CLK,          // system clock 100 MHz
  input  wire logic        SYS_RST,      // async power-up reset
  input  wire logic        SEL_N,        // chip select pin, active low
  input  wire logic        SCLK,         // serial clock pin
  input  wire logic        SDI,          // serial data in pin
  input  wire logic        WP_N,         // write-protect pin, active low
  input  wire logic        RESET_N,      // reset pin, active low
  input  wire logic        CYCLE_BUSY,   // array controls report cycle
  input  wire logic [7:0]  ARRAY_RDATA,  // byte read from array
  output logic             SDO,          // serial data out
  output logic             SDO_OE_N,     // output enable, low drives
  output logic             CMD_GO,       // one-cycle execute pulse
  output logic [3:0]       CMD_KIND,     // command kind to array
  output logic [15:0]      CMD_ADDR,     // start address
  output logic             RD_REQ,       // array byte fetch pulse
  output logic [15:0]      RD_ADDR,      // fetch address
  output logic             WDATA_VLD,    // data byte strobe
  output logic [7:0]       WDATA,        // data byte
  output logic             FIELD_WR,     // status write strobe
  output logic [3:0]       FIELD_OUT,    // current protect field
  output logic             LATCH_OUT     // write permit latch
);
  logic [2:0] pins_s;
  logic       sel_n_s, sclk_s, sdi_s, wp_n_s;
  logic       rst_n_s, busy_s;
  logic       sclk_d_ff;
  logic       rise, fall, sel_start, sel_end;
  logic       sel_d_ff;
  sief_pkg::sief_state_t state_ff, nxt_state;
  sief_pkg::sief_cmd_t   cmd_ff;
  logic [2:0]  bit_ff;
  logic [7:0]  sh_ff;
  logic [1:0]  abyte_ff;
  logic [15:0] addr_ff;
  logic [8:0]  dcnt_ff;
  logic        byte_done;
  logic [7:0]  tx_ff;
  logic [1:0]  idx_ff;
  logic [7:0]  nxt_byte;
  logic        lead_ff;
  logic        latch_ff;
  logic [3:0]  field_ff;
  logic        fld_pend_ff;
  logic [7:0]  fld_val_ff;
  logic        aligned;

  // pins enter through two flip-flops
  sief_sync #(.W(6), .INIT(`SIEF_PIN_IDLE)) u_sync (
    .clk  (CLK),
    .rst  (SYS_RST),
    .d    ({SEL_N, SCLK, SDI, WP_N, RESET_N, CYCLE_BUSY}),
    .q    ({sel_n_s, sclk_s, sdi_s, pins_s})
  );
  assign wp_n_s  = pins_s[2];
  assign rst_n_s = pins_s[1];
  assign busy_s  = pins_s[0];

  function automatic sief_pkg::sief_cmd_t decode(input logic [7:0] op);
    unique case (op)
      `SIEF_OP_LATCH_SET:    decode = sief_pkg::CMD_LATCH_SET;
      `SIEF_OP_LATCH_CLEAR:  decode = sief_pkg::CMD_LATCH_CLEAR;
      `SIEF_OP_IDENT_READ:   decode = sief_pkg::CMD_IDENT;
      `SIEF_OP_STATUS_READ:  decode = sief_pkg::CMD_STATUS_RD;
      `SIEF_OP_STATUS_WRITE: decode = sief_pkg::CMD_STATUS_WR;
      `SIEF_OP_DATA_READ:    decode = sief_pkg::CMD_DATA_RD;
      `SIEF_OP_PAGE_REWRITE: decode = sief_pkg::CMD_REWRITE;
      `SIEF_OP_PAGE_BURN:    decode = sief_pkg::CMD_BURN;
      `SIEF_OP_PAGE_CLEAR:   decode = sief_pkg::CMD_PAGE_CLR;
      `SIEF_OP_SECTOR_CLEAR: decode = sief_pkg::CMD_SECTOR_CLR;
      default:               decode = sief_pkg::CMD_NONE;
    endcase
  endfunction : decode

  function automatic logic is_modify(input sief_pkg::sief_cmd_t c);
    is_modify = (c == sief_pkg::CMD_REWRITE) || (c == sief_pkg::CMD_BURN) ||
                (c == sief_pkg::CMD_PAGE_CLR) ||
                (c == sief_pkg::CMD_SECTOR_CLR);
  endfunction : is_modify

  // field value above 15 cannot exist in four bits: top page stays out
  function automatic logic in_fast(input logic [15:0] a,
                                   input logic [3:0] n);
    in_fast = ({1'b0, a[`SIEF_PAGE_HI:`SIEF_PAGE_LO]} < {1'b0, n});
  endfunction : in_fast

  function automatic logic [7:0] status_byte(input logic l, input logic b,
                                             input logic [3:0] f,
                                             input logic wp);
    status_byte = {2'b00, (wp ? f : 4'h0), l, b};
  endfunction : status_byte

  assign rise      = sclk_s & ~sclk_d_ff;
  assign fall      = ~sclk_s & sclk_d_ff;
  assign sel_start = sel_d_ff & ~sel_n_s;
  assign sel_end   = ~sel_d_ff & sel_n_s;
  assign byte_done = rise && (bit_ff == `SIEF_BYTE_BITS);
  assign aligned   = (bit_ff == 3'h0);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sclk_d_ff <= 1'b0;
      sel_d_ff  <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_s;
      sel_d_ff  <= sel_n_s;
    end
  end

  // bit framing, msb first on rising edges
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bit_ff <= 3'h0;
      sh_ff  <= 8'h00;
    end else if (sel_n_s) begin
      bit_ff <= 3'h0;
    end else if (rise) begin
      bit_ff <= bit_ff + 3'h1;
      sh_ff  <= {sh_ff[6:0], sdi_s};
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      sief_pkg::ST_IDLE:   if (sel_start) nxt_state = sief_pkg::ST_OPCODE;
      sief_pkg::ST_OPCODE: if (byte_done) begin
        unique case (decode({sh_ff[6:0], sdi_s}))
          sief_pkg::CMD_NONE:       nxt_state = sief_pkg::ST_IGNORE;
          sief_pkg::CMD_LATCH_SET,
          sief_pkg::CMD_LATCH_CLEAR:nxt_state = sief_pkg::ST_IGNORE;
          sief_pkg::CMD_STATUS_RD:  nxt_state = sief_pkg::ST_OUT;
          sief_pkg::CMD_IDENT:      nxt_state = busy_s ?
                                      sief_pkg::ST_IGNORE : sief_pkg::ST_OUT;
          sief_pkg::CMD_STATUS_WR:  nxt_state = sief_pkg::ST_DATA_IN;
          default:                  nxt_state = sief_pkg::ST_ADDR;
        endcase
      end
      sief_pkg::ST_ADDR: if (byte_done && abyte_ff == `SIEF_ADDR_BYTES - 2'h1)
        nxt_state = (cmd_ff == sief_pkg::CMD_DATA_RD) ? sief_pkg::ST_OUT :
                    sief_pkg::ST_DATA_IN;
      sief_pkg::ST_DATA_IN, sief_pkg::ST_OUT, sief_pkg::ST_IGNORE: ;
      default: nxt_state = sief_pkg::ST_IDLE;
    endcase
    if (sel_n_s) nxt_state = sief_pkg::ST_IDLE;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_ff <= sief_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // command, address and data byte capture
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cmd_ff   <= sief_pkg::CMD_NONE;
      abyte_ff <= 2'h0;
      addr_ff  <= 16'h0000;
      dcnt_ff  <= 9'h000;
    end else if (state_ff == sief_pkg::ST_OPCODE && byte_done) begin
      cmd_ff   <= decode({sh_ff[6:0], sdi_s});
      abyte_ff <= 2'h0;
      dcnt_ff  <= 9'h000;
    end else if (state_ff == sief_pkg::ST_ADDR && byte_done) begin
      addr_ff  <= {addr_ff[7:0], sh_ff[6:0], sdi_s};
      abyte_ff <= abyte_ff + 2'h1;
    end else if (state_ff == sief_pkg::ST_DATA_IN && byte_done) begin
      dcnt_ff  <= dcnt_ff + 9'h001;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      WDATA_VLD <= 1'b0;
      WDATA     <= 8'h00;
    end else begin
      WDATA_VLD <= state_ff == sief_pkg::ST_DATA_IN && byte_done &&
                   cmd_ff != sief_pkg::CMD_STATUS_WR && !busy_s;
      if (byte_done) WDATA <= {sh_ff[6:0], sdi_s};
    end
  end

  // status write data held for the deselect check
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      fld_pend_ff <= 1'b0;
      fld_val_ff  <= 8'h00;
    end else if (sel_start) begin
      fld_pend_ff <= 1'b0;
    end else if (state_ff == sief_pkg::ST_DATA_IN && byte_done &&
                 cmd_ff == sief_pkg::CMD_STATUS_WR) begin
      fld_pend_ff <= ~fld_pend_ff;
      fld_val_ff  <= {sh_ff[6:0], sdi_s};
    end
  end

  // execution at deselect
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      latch_ff <= 1'b0;
      field_ff <= `SIEF_FIELD_RESET;
      CMD_GO   <= 1'b0;
      CMD_KIND <= 4'h0;
      CMD_ADDR <= 16'h0000;
      FIELD_WR <= 1'b0;
    end else begin
      CMD_GO   <= 1'b0;
      FIELD_WR <= 1'b0;
      if (!rst_n_s) begin
        latch_ff <= 1'b0;
      end else if (sel_end && aligned) begin
        unique case (cmd_ff)
          sief_pkg::CMD_LATCH_SET:
            if (state_ff == sief_pkg::ST_IGNORE) latch_ff <= 1'b1;
          sief_pkg::CMD_LATCH_CLEAR:
            if (state_ff == sief_pkg::ST_IGNORE) latch_ff <= 1'b0;
          sief_pkg::CMD_STATUS_WR:
            if (fld_pend_ff && latch_ff && wp_n_s && !busy_s) begin
              field_ff <= fld_val_ff[`SIEF_ST_FIELD_HI:`SIEF_ST_FIELD_LO];
              FIELD_WR <= 1'b1;
              latch_ff <= 1'b0;
            end
          default:
            if (is_modify(cmd_ff) && state_ff != sief_pkg::ST_ADDR &&
                !busy_s && latch_ff) begin
              if (!(!wp_n_s && in_fast(addr_ff, field_ff))) begin
                CMD_GO   <= (cmd_ff == sief_pkg::CMD_PAGE_CLR ||
                             cmd_ff == sief_pkg::CMD_SECTOR_CLR ||
                             dcnt_ff != 9'h000);
                CMD_KIND <= cmd_ff;
                CMD_ADDR <= addr_ff;
                latch_ff <= 1'b0;
              end
            end
        endcase
      end
    end
  end

  always_comb begin
    unique case (cmd_ff)
      sief_pkg::CMD_IDENT:
        nxt_byte = (idx_ff == 2'h1) ? `SIEF_ID_TYPE : `SIEF_ID_SIZE;
      sief_pkg::CMD_STATUS_RD:
        nxt_byte = status_byte(latch_ff, busy_s, field_ff, wp_n_s);
      default: nxt_byte = ARRAY_RDATA;
    endcase
  end

  // serial output: loads on byte ends, shifts on falling edges
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_ff    <= 8'h00;
      idx_ff   <= 2'h0;
      lead_ff  <= 1'b0;
      RD_REQ   <= 1'b0;
      RD_ADDR  <= 16'h0000;
      SDO      <= 1'b0;
      SDO_OE_N <= 1'b1;
    end else begin
      RD_REQ <= 1'b0;
      if (nxt_state == sief_pkg::ST_OUT && state_ff != sief_pkg::ST_OUT) begin
        idx_ff  <= 2'h1;
        lead_ff <= 1'b1; // first fall sends the byte loaded here
        unique case ((state_ff == sief_pkg::ST_OPCODE) ?
                     decode({sh_ff[6:0], sdi_s}) : cmd_ff)
          sief_pkg::CMD_IDENT: tx_ff <= `SIEF_ID_MAKER;
          sief_pkg::CMD_STATUS_RD:
            tx_ff <= status_byte(latch_ff, busy_s, field_ff, wp_n_s);
          default: begin
            tx_ff   <= ARRAY_RDATA;
            RD_REQ  <= !busy_s;
            RD_ADDR <= {addr_ff[7:0], sh_ff[6:0], sdi_s};
          end
        endcase
      end else if (state_ff == sief_pkg::ST_OUT && fall) begin
        SDO      <= tx_ff[7];
        SDO_OE_N <= 1'b0;
        tx_ff    <= {tx_ff[6:0], 1'b0};
        lead_ff  <= 1'b0;
        if (bit_ff == 3'h0 && !lead_ff && idx_ff != 2'h0) begin
          SDO   <= nxt_byte[7];
          tx_ff <= {nxt_byte[6:0], 1'b0};
          if (cmd_ff == sief_pkg::CMD_IDENT)
            idx_ff <= (idx_ff == 2'h2) ? 2'h0 : 2'h2;
          if (cmd_ff == sief_pkg::CMD_DATA_RD) begin
            RD_ADDR <= RD_ADDR + 16'h0001;
            RD_REQ  <= !busy_s;
          end
        end
      end
      if (state_ff != sief_pkg::ST_OUT) SDO_OE_N <= 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      FIELD_OUT <= `SIEF_FIELD_RESET;
      LATCH_OUT <= 1'b0;
    end else begin
      FIELD_OUT <= field_ff;
      LATCH_OUT <= latch_ff;
    end
  end
endmodule : sief_front_end

/* File: dv/sief_asserts.sv */
// port assertions for the instruction front end
`timescale 1ns/100ps
module sief_asserts (
  input wire logic       CLK,        // system clock
  input wire logic       SYS_RST,    // async reset
  input wire logic       SEL_N,      // chip select pin
  input wire logic       WP_N,       // write-protect pin
  input wire logic       RESET_N,    // reset pin
  input wire logic       CYCLE_BUSY, // array cycle running
  input wire logic       SDO_OE_N,   // output enable
  input wire logic       CMD_GO,     // execute pulse
  input wire logic [3:0] CMD_KIND,   // command kind
  input wire logic       FIELD_WR,   // field strobe
  input wire logic [3:0] FIELD_OUT,  // protect field
  input wire logic       LATCH_OUT   // write permit latch
);
  logic is_mod;  // execute pulse of a modifying command
  assign is_mod = CMD_GO && CMD_KIND >= 4'(sief_pkg::CMD_REWRITE);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  sequence s_desel;
    SEL_N [*6];
  endsequence
  sequence s_pin_rst;
    !RESET_N [*6];
  endsequence
  sequence s_busy;
    CYCLE_BUSY [*6];
  endsequence
  AST_OE_IDLE: assert property (s_desel |-> SDO_OE_N)
    else $error("output driven while deselected");
  AST_GO_DESEL: assert property (CMD_GO |-> SEL_N && $past(SEL_N, 3))
    else $error("execute pulse without deselection");
  AST_GO_PULSE: assert property (CMD_GO |=> !CMD_GO)
    else $error("execute pulse longer than one cycle");
  AST_GO_LATCH: assert property (is_mod |-> $past(LATCH_OUT))
    else $error("modify executed with latch clear");
  AST_LATCH_CLR: assert property (is_mod && WP_N |-> ##[0:4] !LATCH_OUT)
    else $error("latch kept after modify");
  AST_PIN_RST: assert property (s_pin_rst |-> !LATCH_OUT)
    else $error("latch set under reset pin");
  AST_BUSY_REFUSE: assert property (s_busy |-> !is_mod)
    else $error("modify executed while busy");
  AST_LATCH_RISE: assert property ($rose(LATCH_OUT) |-> SEL_N && RESET_N)
    else $error("latch set while selected");
  AST_FIELD_HOLD: assert property ($changed(FIELD_OUT) |->
    FIELD_WR || $past(FIELD_WR))
    else $error("field changed without strobe");
endmodule : sief_asserts
bind sief_front_end sief_asserts chk_u (
  .CLK, .SYS_RST, .SEL_N, .WP_N, .RESET_N, .CYCLE_BUSY, .SDO_OE_N,
  .CMD_GO, .CMD_KIND, .FIELD_WR, .FIELD_OUT, .LATCH_OUT
);

/* File: dv/sief_spi_master.sv */
// spi master model, clock mode zero, clock still between frames
`timescale 1ns/100ps
module sief_spi_master (
  input  wire logic clk,   // bench clock
  input  wire logic sdo,   // serial data from the device
  output logic      sel_n, // chip select, active low
  output logic      sclk,  // serial clock
  output logic      sdi    // serial data to the device
);
  logic [7:0] rx_byte; // last byte read back
  event       rx_done; // one per byte read back
  initial begin
    sel_n = 1'b1;
    sclk  = 1'b0;
    sdi   = 1'b0;
  end
  task automatic start();
    @(posedge clk);
    sel_n <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : start
  // released data line shows the inverse of its last level
  task automatic stop();
    repeat (4) @(posedge clk);
    sel_n <= 1'b1;
    sdi   <= ~sdi;
    repeat (12) @(posedge clk);
  endtask : stop
  task automatic shift(input logic [7:0] tx, input int n, input bit rd);
    logic [7:0] v;
    for (int i = 7; i > 7 - n; i--) begin
      sdi <= tx[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      v = {v[6:0], sdo};
      sclk <= 1'b0;
    end
    if (rd) begin
      rx_byte = v;
      -> rx_done;
    end
  endtask : shift
endmodule : sief_spi_master

/* File: dv/test_spi_eeprom_instruction_front_end.sv */
// self-checking bench for the instruction front end
`timescale 1ns/100ps
`include "sief_regs.svh"
module test_spi_eeprom_instruction_front_end;
  logic        CLK, SYS_RST, wp_n, reset_n, busy, sel_n, sclk, sdi;
  logic        sdo, sdo_oe_n, cmd_go, latch_out, rd_req, wdata_vld, sdo_bus;
  logic [7:0]  ard, wdata, tx[$], exp_byte[$];
  logic [7:0]  ops[4] = '{8'h02, 8'h0a, 8'hdb, 8'hd8};
  logic [3:0]  cmd_kind, field_out;
  logic [15:0] cmd_addr, rd_addr, a;
  logic [19:0] exp_cmd[$], exp_rd[$];
  int          failures, checked;
  sief_front_end dut_u (
    .CLK, .SYS_RST, .SEL_N(sel_n), .SCLK(sclk), .SDI(sdi), .WP_N(wp_n),
    .RESET_N(reset_n), .CYCLE_BUSY(busy), .ARRAY_RDATA(ard), .SDO(sdo),
    .SDO_OE_N(sdo_oe_n), .CMD_GO(cmd_go), .CMD_KIND(cmd_kind),
    .CMD_ADDR(cmd_addr), .RD_REQ(rd_req), .RD_ADDR(rd_addr),
    .WDATA_VLD(wdata_vld), .WDATA(wdata),
    .FIELD_WR(), .FIELD_OUT(field_out), .LATCH_OUT(latch_out)
  );
  // released output line shows the inverse of its last level
  assign sdo_bus = sdo_oe_n ? ~sdo : sdo;
  sief_spi_master m_u (
    .clk(CLK), .sdo(sdo_bus), .sel_n(sel_n), .sclk(sclk), .sdi(sdi)
  );
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ckl(input logic exp);
    chk({19'h0, latch_out}, {19'h0, exp});
  endtask : ckl
  task automatic frame(input logic [7:0] b[$], input int nrd);
    m_u.start();
    foreach (b[i]) m_u.shift(b[i], 8, 1'b0);
    repeat (nrd) m_u.shift(8'h00, 8, 1'b1);
    m_u.stop();
  endtask : frame
  task automatic finish_test();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  always @(posedge CLK) begin
    if (cmd_go === 1'b1 && cmd_kind >= 4'(sief_pkg::CMD_REWRITE))
      chk({cmd_kind, cmd_addr}, exp_cmd.size() ? exp_cmd.pop_front() : 'x);
    if (rd_req === 1'b1)
      chk({4'h0, rd_addr}, exp_rd.size() ? exp_rd.pop_front() : 'x);
    if (wdata_vld === 1'b1)
      chk({12'h0, wdata}, {12'h0, ard});
  end
  always @(m_u.rx_done) begin
    chk({12'h0, m_u.rx_byte}, {12'h0, exp_byte.pop_front()});
  end
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial begin
    #500000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    void'($urandom(52795));
    {SYS_RST, wp_n, reset_n, busy} = 4'b1110;
    ard = 8'($urandom());
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    repeat (4) @(posedge CLK);
    frame('{8'h06}, 0);
    ckl(1'b1);
    frame('{8'h04}, 0);
    ckl(1'b0);
    m_u.start();
    m_u.shift(8'h06, 8, 1'b0);
    m_u.shift(8'h00, 1, 1'b0);
    m_u.stop();
    ckl(1'b0);
    frame('{8'h06}, 0);
    frame('{8'hc3, 8'h02}, 0);
    ckl(1'b1);
    reset_n <= 1'b0;
    repeat (8) @(posedge CLK);
    ckl(1'b0);
    reset_n <= 1'b1;
    $display("test latch done");
    exp_byte = '{`SIEF_ID_MAKER, `SIEF_ID_TYPE, `SIEF_ID_SIZE, `SIEF_ID_MAKER};
    frame('{8'h9f}, 3);
    frame('{8'h9f}, 1);
    frame('{8'h06}, 0);
    ckl(1'b1);
    frame('{8'h01, 8'h3c}, 0);
    chk({16'h0, field_out}, 20'hf);
    frame('{8'h04}, 0);
    exp_byte = '{8'h3c, 8'h3c, 8'h00, 8'h3f};
    frame('{8'h05}, 2);
    wp_n <= 1'b0;
    frame('{8'h05}, 1);
    wp_n <= 1'b1;
    busy <= 1'b1;
    frame('{8'h06}, 0);
    frame('{8'h05}, 1);
    m_u.start();
    m_u.shift(8'h9f, 8, 1'b0);
    m_u.shift(8'h00, 8, 1'b0);
    chk({19'h0, sdo_oe_n}, 20'h1);
    m_u.stop();
    frame('{8'hd8, 8'h00, 8'h00, 8'h00}, 0);
    busy <= 1'b0;
    exp_byte = '{ard, ard};
    exp_rd   = '{20'h00100, 20'h00101, 20'h00102};
    frame('{8'h03, 8'h00, 8'h01, 8'h00}, 2);
    $display("test status done");
    frame('{8'h04}, 0);
    frame('{8'h02, 8'h00, 8'h01, 8'h00, ard}, 0);
    for (int i = 0; i < 4; i++) begin
      a = {4'h0, 12'($urandom())};
      tx = '{ops[i], 8'h00, a[15:8], a[7:0]};
      if (i < 2)
        tx.push_back(ard);
      frame('{8'h06}, 0);
      exp_cmd.push_back({4'(sief_pkg::CMD_REWRITE) + 4'(i), a});
      frame(tx, 0);
      ckl(1'b0);
    end
    $display("test modify done");
    wp_n <= 1'b0;
    frame('{8'h06}, 0);
    frame('{8'hdb, 8'h00, 8'h0e, 8'h00}, 0);
    ckl(1'b1);
    exp_cmd.push_back({4'(sief_pkg::CMD_PAGE_CLR), 16'h0f00});
    frame('{8'hdb, 8'h00, 8'h0f, 8'h00}, 0);
    ckl(1'b0);
    $display("test protect done");
    chk(20'(exp_cmd.size() + exp_byte.size() + exp_rd.size()), 20'h0);
    finish_test();
  end
endmodule : test_spi_eeprom_instruction_front_end
